// file: scc_pkg.sv
package scc_pkg;

  // ------------------------------------------------------------
  // Register indices; byte address is four times the index
  // ------------------------------------------------------------
  localparam logic [6:0] REG_CLK_CTRL    = 7'h03;
  localparam logic [6:0] REG_HS_POL      = 7'h12;
  localparam logic [6:0] REG_VS_CTRL     = 7'h14;
  localparam logic [6:0] REG_VS_WIDTH    = 7'h15;
  localparam logic [6:0] REG_CLAMP_CTRL  = 7'h18;
  localparam logic [6:0] REG_CLAMP_POL   = 7'h1B;
  localparam logic [6:0] REG_SLEEP_CTRL  = 7'h1E;
  localparam logic [6:0] REG_REGEN_LINE_SYNC_OUT_WIDTH = 7'h40;
  localparam logic [6:0] REG_REGEN_LINE_SYNC_OUT_CTRL  = 7'h41;
  localparam logic [6:0] REG_FRAME_SYNC_OUT_CTRL  = 7'h42;
  localparam logic [6:0] REG_CLAMP_DELAY = 7'h43;
  localparam logic [6:0] REG_CLAMP_DUR   = 7'h44;
  localparam logic [6:0] REG_STATUS      = 7'h45;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int BIT_EXT_CLK     = 2;
  localparam int BIT_POL_MANUAL  = 1;
  localparam int BIT_POL_LEVEL   = 0;
  localparam int POS_HS_POL      = 4;
  localparam int POS_VS_POL      = 4;
  localparam int BIT_VS_OVERRIDE = 3;
  localparam int POS_COAST_POL   = 6;
  localparam int BIT_CLAMP_EXT   = 4;
  localparam int POS_CLAMP_POL   = 6;
  localparam int BIT_SLEEP_MAN   = 4;
  localparam int BIT_SLEEP_REG   = 3;
  localparam int BIT_SLEEP_POL   = 2;
  localparam int BIT_OUT_POL     = 0;
  localparam int BIT_VS_SEPARATE = 1;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [7:0] RST_ZERO        = 8'h00;
  localparam logic [7:0] RST_CLAMP_CTRL  = 8'hC0;
  localparam logic [7:0] RST_REGEN_LINE_SYNC_OUT_WIDTH = 8'h20;
  localparam logic [7:0] RST_REGEN_LINE_SYNC_OUT_CTRL  = 8'h01;
  localparam logic [7:0] RST_FRAME_SYNC_OUT_CTRL  = 8'h01;
  localparam logic [7:0] RST_CLAMP_DELAY = 8'h04;
  localparam logic [7:0] RST_CLAMP_DUR   = 8'h10;
  localparam logic [1:0] STRAP_WAIT      = 2'h3;

  // Input index order for synchronisers and polarity detectors
  localparam int IN_HS    = 0;
  localparam int IN_VS    = 1;
  localparam int IN_CLAMP = 2;
  localparam int IN_COAST = 3;
  localparam int IN_SLEEP = 4;
  localparam int IN_STRAP = 5;
  localparam int N_IN     = 6;
  localparam int N_POL    = 4;

  typedef enum logic [1:0] {CL_IDLE, CL_DELAY, CL_ON} scc_clamp_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [8:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } scc_wb_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] dat;
  } scc_wb_rsp_type;

endpackage

// file: scc_sync_ctrl.sv
`timescale 1ns/1ps
module scc_sync_ctrl
  import scc_pkg::*;
#(
  parameter int          POL_CNT_W  = 10,
  parameter logic [3:0]  POL_DIV    = 4'hF,
  parameter logic [15:0] VSEP_MIN   = 16'h0100
) (
  input  wire logic           sys_clk,
  input  wire logic           srst,
  input  wire scc_wb_req_type wbReq,
  output scc_wb_rsp_type      wbRsp,
  input  wire logic           lineSyncIn,
  input  wire logic           frameSyncIn,
  input  wire logic           clampIn,
  input  wire logic           holdoverIn,
  input  wire logic           sleep_pin,
  input  wire logic           frameSyncPinIn,
  output logic                frame_sync_out,
  output logic                frameSyncOe,
  output logic                regen_line_sync_out,
  output logic                addr_lsb_strap,
  output logic                clampActive,
  output logic                pllHoldover,
  output logic                extClkSelect,
  output logic                sleepActive
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [7:0]                    clkCtrl;
    logic [7:0]                    hsPol;
    logic [7:0]                    vsCtrl;
    logic [7:0]                    vsWidth;
    logic [7:0]                    clampCtrl;
    logic [7:0]                    clampPol;
    logic [7:0]                    sleepCtrl;
    logic [7:0]                    hsoutWidth;
    logic [7:0]                    hsoutCtrl;
    logic [7:0]                    vsoutCtrl;
    logic [7:0]                    clampDelay;
    logic [7:0]                    clampDur;
    logic                          ack;
    logic [7:0]                    rdData;
    logic [N_IN-1:0]               meta;
    logic [N_IN-1:0]               sync;
    logic [N_POL-1:0][POL_CNT_W-1:0] polCnt;
    logic [3:0]                    divCnt;
    logic                          hsPrev;
    logic                          vsPrev;
    logic [7:0]                    hsoutCnt;
    logic                          hsoutOn;
    scc_clamp_type                 clampState;
    logic [7:0]                    clampCnt;
    logic [15:0]                   sepCnt;
    logic                          sepOn;
    logic                          vsoutOn;
    logic [7:0]                    vsoutCnt;
    logic [1:0]                    strapCnt;
    logic                          strapDone;
    logic                          strap;
    logic                          lineOut;
    logic                          frameOut;
    logic                          clampOut;
    logic                          holdOut;
    logic                          extClkOut;
    logic                          sleepOut;
  } scc_state_type;

  scc_state_type s_q;
  scc_state_type s_d;

  logic [N_IN-1:0]  pinVec;
  logic [N_POL-1:0] autoActive;
  logic [N_POL-1:0] activeLvl;
  logic [N_POL-1:0] actIn;
  logic             polTick;
  logic             hsLead;
  logic             hsTrail;
  logic             vsSrc;
  logic             vsSrcPrev;
  logic             vsLead;
  logic             vsTrail;
  logic             sleepPinAct;
  logic             busHit;
  logic [6:0]       regIdx;
  logic [7:0]       rdMux;

  // ------------------------------------------------------------
  // Pin vector and bus decode
  // ------------------------------------------------------------
  assign pinVec = {frameSyncPinIn, sleep_pin, holdoverIn, clampIn, frameSyncIn, lineSyncIn};
  assign regIdx = wbReq.adr[8:2];
  assign busHit = wbReq.cyc & wbReq.stb & ~s_q.ack;
  assign polTick = (s_q.divCnt == POL_DIV);

  // ------------------------------------------------------------
  // Polarity choice per line, frame, clamp and coast input: manual level or majority-based guess
  // ------------------------------------------------------------
  // Active level is the minority level, since sync pulses are short
  genvar gi;
  generate
    for (gi = 0; gi < N_POL; gi++) begin : g_pol
      logic [1:0] field;
      if (gi == IN_HS) begin : g_hs
        assign field = s_q.hsPol[POS_HS_POL +: 2];
      end else if (gi == IN_VS) begin : g_vs
        assign field = s_q.vsCtrl[POS_VS_POL +: 2];
      end else if (gi == IN_CLAMP) begin : g_cl
        assign field = s_q.clampPol[POS_CLAMP_POL +: 2];
      end else begin : g_co
        assign field = s_q.clampCtrl[POS_COAST_POL +: 2];
      end
      assign autoActive[gi] = s_q.polCnt[gi][POL_CNT_W-1];
      assign activeLvl[gi]  = field[BIT_POL_MANUAL] ? field[BIT_POL_LEVEL]
                                                    : autoActive[gi];
      assign actIn[gi]      = ~(s_q.sync[gi] ^ activeLvl[gi]);
    end
  endgenerate

  // ------------------------------------------------------------
  // Edge detectors and frame source
  // ------------------------------------------------------------
  assign hsLead  = actIn[IN_HS] & ~s_q.hsPrev;
  assign hsTrail = ~actIn[IN_HS] & s_q.hsPrev;
  assign vsSrc   = s_q.vsoutCtrl[BIT_VS_SEPARATE] ? s_q.sepOn : actIn[IN_VS];
  assign vsSrcPrev = s_q.vsPrev;
  assign vsLead  = vsSrc & ~vsSrcPrev;
  assign vsTrail = ~vsSrc & vsSrcPrev;
  assign sleepPinAct = ~(s_q.sync[IN_SLEEP] ^ s_q.sleepCtrl[BIT_SLEEP_POL]);

  // ------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------
  always_comb begin
    unique case (regIdx)
      REG_CLK_CTRL:    rdMux = s_q.clkCtrl;
      REG_HS_POL:      rdMux = s_q.hsPol;
      REG_VS_CTRL:     rdMux = s_q.vsCtrl;
      REG_VS_WIDTH:    rdMux = s_q.vsWidth;
      REG_CLAMP_CTRL:  rdMux = s_q.clampCtrl;
      REG_CLAMP_POL:   rdMux = s_q.clampPol;
      REG_SLEEP_CTRL:  rdMux = s_q.sleepCtrl;
      REG_REGEN_LINE_SYNC_OUT_WIDTH: rdMux = s_q.hsoutWidth;
      REG_REGEN_LINE_SYNC_OUT_CTRL:  rdMux = s_q.hsoutCtrl;
      REG_FRAME_SYNC_OUT_CTRL:  rdMux = s_q.vsoutCtrl;
      REG_CLAMP_DELAY: rdMux = s_q.clampDelay;
      REG_CLAMP_DUR:   rdMux = s_q.clampDur;
      REG_STATUS:      rdMux = {s_q.strap, s_q.sleepOut, s_q.holdOut, s_q.clampOut,
                                activeLvl};
      default:         rdMux = RST_ZERO;
    endcase
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    s_d = s_q;

    // ------------------------------------------------------------
    // Bus slave: one wait state, unmapped reads give zero
    // ------------------------------------------------------------
    s_d.ack = busHit;
    if (busHit) begin
      s_d.rdData = wbReq.we ? RST_ZERO : rdMux;
    end
    if (busHit && wbReq.we && wbReq.sel[0]) begin
      unique case (regIdx)
        REG_CLK_CTRL:    s_d.clkCtrl    = wbReq.dat[7:0];
        REG_HS_POL:      s_d.hsPol      = wbReq.dat[7:0];
        REG_VS_CTRL:     s_d.vsCtrl     = wbReq.dat[7:0];
        REG_VS_WIDTH:    s_d.vsWidth    = wbReq.dat[7:0];
        REG_CLAMP_CTRL:  s_d.clampCtrl  = wbReq.dat[7:0];
        REG_CLAMP_POL:   s_d.clampPol   = wbReq.dat[7:0];
        REG_SLEEP_CTRL:  s_d.sleepCtrl  = wbReq.dat[7:0];
        REG_REGEN_LINE_SYNC_OUT_WIDTH: s_d.hsoutWidth = wbReq.dat[7:0];
        REG_REGEN_LINE_SYNC_OUT_CTRL:  s_d.hsoutCtrl  = wbReq.dat[7:0];
        REG_FRAME_SYNC_OUT_CTRL:  s_d.vsoutCtrl  = wbReq.dat[7:0];
        REG_CLAMP_DELAY: s_d.clampDelay = wbReq.dat[7:0];
        REG_CLAMP_DUR:   s_d.clampDur   = wbReq.dat[7:0];
        default:         s_d.rdData     = RST_ZERO;
      endcase
    end

    // ------------------------------------------------------------
    // Two-flop synchronisers on every pin
    // ------------------------------------------------------------
    s_d.meta = pinVec;
    s_d.sync = s_q.meta;

    // ------------------------------------------------------------
    // Majority counters, sampled on a slow enable
    // ------------------------------------------------------------
    s_d.divCnt = polTick ? 4'h0 : s_q.divCnt + 4'h1;
    if (polTick) begin
      for (int i = 0; i < N_POL; i++) begin
        if (s_q.sync[i] && s_q.polCnt[i] != {1'b0, {(POL_CNT_W-1){1'b1}}}) begin
          s_d.polCnt[i] = s_q.polCnt[i] + {{(POL_CNT_W-1){1'b0}}, 1'b1};
        end else if (!s_q.sync[i] && s_q.polCnt[i] != {1'b1, {(POL_CNT_W-1){1'b0}}}) begin
          s_d.polCnt[i] = s_q.polCnt[i] - {{(POL_CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end

    s_d.hsPrev = actIn[IN_HS];
    s_d.vsPrev = vsSrc;

    // ------------------------------------------------------------
    // Regenerated line sync: restarts on each leading edge
    // ------------------------------------------------------------
    if (hsLead) begin
      s_d.hsoutOn  = (s_q.hsoutWidth != RST_ZERO);
      s_d.hsoutCnt = s_q.hsoutWidth;
    end else if (s_q.hsoutOn) begin
      s_d.hsoutCnt = s_q.hsoutCnt - 8'h01;
      s_d.hsoutOn  = (s_q.hsoutCnt > 8'h01);
    end
    s_d.lineOut = ~(s_d.hsoutOn ^ s_q.hsoutCtrl[BIT_OUT_POL]);

    // ------------------------------------------------------------
    // Internal clamp timer, restarted by every trailing edge
    // ------------------------------------------------------------
    // Restart per line, so a missed edge costs one line only
    if (hsTrail) begin
      s_d.clampState = (s_q.clampDelay == RST_ZERO) ? CL_ON : CL_DELAY;
      s_d.clampCnt   = (s_q.clampDelay == RST_ZERO) ? s_q.clampDur : s_q.clampDelay;
    end else begin
      unique case (s_q.clampState)
        CL_IDLE: s_d.clampCnt = RST_ZERO;
        CL_DELAY: begin
          s_d.clampCnt = s_q.clampCnt - 8'h01;
          if (s_q.clampCnt == 8'h01) begin
            s_d.clampState = CL_ON;
            s_d.clampCnt   = s_q.clampDur;
          end
        end
        CL_ON: begin
          s_d.clampCnt = s_q.clampCnt - 8'h01;
          if (s_q.clampCnt <= 8'h01) begin
            s_d.clampState = CL_IDLE;
          end
        end
      endcase
    end
    if (s_q.clampCtrl[BIT_CLAMP_EXT]) begin
      s_d.clampOut = actIn[IN_CLAMP];
    end else begin
      s_d.clampOut = (s_d.clampState == CL_ON) && (s_d.clampCnt != RST_ZERO);
    end

    // ------------------------------------------------------------
    // Frame sync separated from composite line input
    // ------------------------------------------------------------
    if (actIn[IN_HS]) begin
      if (s_q.sepCnt != VSEP_MIN) begin
        s_d.sepCnt = s_q.sepCnt + 16'h0001;
      end
      s_d.sepOn = (s_q.sepCnt == VSEP_MIN);
    end else begin
      s_d.sepCnt = 16'h0000;
      s_d.sepOn  = 1'b0;
    end

    // ------------------------------------------------------------
    // Frame sync width from source or counted in lines
    // ------------------------------------------------------------
    if (s_q.vsCtrl[BIT_VS_OVERRIDE]) begin
      if (vsLead) begin
        s_d.vsoutOn  = (s_q.vsWidth != RST_ZERO);
        s_d.vsoutCnt = s_q.vsWidth;
      end else if (s_q.vsoutOn && hsLead) begin
        s_d.vsoutCnt = s_q.vsoutCnt - 8'h01;
        s_d.vsoutOn  = (s_q.vsoutCnt > 8'h01);
      end
    end else begin
      s_d.vsoutOn  = vsLead | (s_q.vsoutOn & ~vsTrail);
      s_d.vsoutCnt = RST_ZERO;
    end
    s_d.frameOut = ~(s_d.vsoutOn ^ s_q.vsoutCtrl[BIT_OUT_POL]);

    // ------------------------------------------------------------
    // Clock source and holdover are decoded apart
    // ------------------------------------------------------------
    s_d.extClkOut = s_q.clkCtrl[BIT_EXT_CLK];
    s_d.holdOut   = actIn[IN_COAST];

    // ------------------------------------------------------------
    // Manual sleep only when selected
    // ------------------------------------------------------------
    s_d.sleepOut = s_q.sleepCtrl[BIT_SLEEP_MAN] &
                   (s_q.sleepCtrl[BIT_SLEEP_REG] | sleepPinAct);

    // ------------------------------------------------------------
    // Strap: pin left undriven until synchroniser has settled
    // ------------------------------------------------------------
    if (!s_q.strapDone) begin
      if (s_q.strapCnt == STRAP_WAIT) begin
        s_d.strap     = s_q.sync[IN_STRAP];
        s_d.strapDone = 1'b1;
      end else begin
        s_d.strapCnt = s_q.strapCnt + 2'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      s_q            <= '0;
      s_q.clampCtrl  <= RST_CLAMP_CTRL;
      s_q.hsoutWidth <= RST_REGEN_LINE_SYNC_OUT_WIDTH;
      s_q.hsoutCtrl  <= RST_REGEN_LINE_SYNC_OUT_CTRL;
      s_q.vsoutCtrl  <= RST_FRAME_SYNC_OUT_CTRL;
      s_q.clampDelay <= RST_CLAMP_DELAY;
      s_q.clampDur   <= RST_CLAMP_DUR;
      s_q.clampState <= CL_IDLE;
      // Auto polarity starts active high: idle-low pins give no false edge
      s_q.polCnt     <= {N_POL{{1'b1, {(POL_CNT_W-1){1'b0}}}}};
      s_q.lineOut    <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign wbRsp.ack           = s_q.ack;
  assign wbRsp.dat           = {24'h00_0000, s_q.rdData};
  assign frame_sync_out      = s_q.frameOut;
  assign frameSyncOe         = s_q.strapDone;
  assign regen_line_sync_out = s_q.lineOut;
  assign addr_lsb_strap      = s_q.strap;
  assign clampActive         = s_q.clampOut;
  assign pllHoldover         = s_q.holdOut;
  assign extClkSelect        = s_q.extClkOut;
  assign sleepActive         = s_q.sleepOut;

endmodule

// file: scc_sync_ctrl_assertions.sv
`timescale 1ns/1ps
module scc_sync_ctrl_assertions
  import scc_pkg::*;
(
  input wire logic           sys_clk,
  input wire logic           srst,
  input wire scc_wb_req_type wbReq,
  input wire scc_wb_rsp_type wbRsp,
  input wire logic           holdoverIn,
  input wire logic           frameSyncOe,
  input wire logic           addr_lsb_strap,
  input wire logic           regen_line_sync_out,
  input wire logic           pllHoldover
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (srst);

  // Length of the present high run; assumes reset width and polarity
  logic [7:0] hiCnt_q;
  always_ff @(posedge sys_clk) begin
    hiCnt_q <= (srst || !regen_line_sync_out) ? 8'h00 : hiCnt_q + 8'h01;
  end

  a_ack_next: assert property (wbReq.cyc && wbReq.stb && !wbRsp.ack |=> wbRsp.ack)
    else $error("ack missing one cycle after request");
  a_ack_single: assert property (wbRsp.ack |=> !wbRsp.ack)
    else $error("ack longer than one cycle");
  a_ack_cause: assert property (wbRsp.ack |-> $past(wbReq.cyc && wbReq.stb))
    else $error("ack without request");
  a_rdata_upper: assert property (wbRsp.ack |-> wbRsp.dat[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");
  a_strap_release: assert property ($fell(srst) |-> !frameSyncOe [*4] ##1 frameSyncOe)
    else $error("strap pin released at wrong edge");
  a_oe_sticky: assert property (frameSyncOe |=> frameSyncOe)
    else $error("frame sync enable dropped");
  a_strap_hold: assert property (frameSyncOe |=> $stable(addr_lsb_strap))
    else $error("strap value changed after capture");
  a_holdover_follow: assert property ($rose(holdoverIn) |-> ##[3:4] pllHoldover)
    else $error("holdover not applied");
  a_line_width: assert property ($fell(regen_line_sync_out) |-> hiCnt_q == 8'h20)
    else $error("line sync pulse width wrong");

  c_read: cover property (wbRsp.ack && !wbReq.we);
  c_hold: cover property ($rose(pllHoldover));
  c_line: cover property ($fell(regen_line_sync_out));
endmodule

// file: scc_src_model.sv
`timescale 1ns/1ps
module scc_src_model (
  input  wire logic sys_clk,
  input  wire logic lineOn,
  input  wire logic strapLvl,
  input  wire logic frameSyncOe,
  input  wire logic frame_sync_out,
  output logic      lineSyncIn,
  output logic      frameSyncPinIn
);
  int cnt = 0;
  initial lineSyncIn = 1'b0;
  // Line period 64 cycles, active high pulse of 8
  always @(posedge sys_clk) begin
    cnt <= (cnt == 63) ? 0 : cnt + 1;
    lineSyncIn <= lineOn && (cnt < 8);
  end
  // Strap resistor decides only while the pin is released
  assign frameSyncPinIn = frameSyncOe ? frame_sync_out : strapLvl;
endmodule

// file: scc_sync_ctrl_tb.sv
`timescale 1ns/1ps
module scc_sync_ctrl_tb
  import scc_pkg::*;
;
  logic           sys_clk = 1'b0, srst = 1'b1;
  scc_wb_req_type wbReq = '0;
  scc_wb_rsp_type wbRsp;
  logic           frameSyncIn = 1'b0, clampIn = 1'b0, holdoverIn = 1'b0, sleep_pin = 1'b0;
  logic           lineOn = 1'b0, strapLvl = 1'b1, lineSyncIn, frameSyncPinIn;
  logic           frame_sync_out, frameSyncOe, regen_line_sync_out, addr_lsb_strap;
  logic           clampActive, pllHoldover, extClkSelect, sleepActive;
  int             errorCnt = 0, samplesChecked = 0, a, b, d;
  logic [6:0]     ri[13] = '{7'h03, 7'h12, 7'h14, 7'h15, 7'h18, 7'h1B, 7'h1E,
                             7'h40, 7'h41, 7'h42, 7'h43, 7'h44, 7'h20};
  logic [7:0]     re[13] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hC0, 8'h00, 8'h00,
                             8'h20, 8'h01, 8'h01, 8'h04, 8'h10, 8'h00};
  logic [7:0]     sr[6] = '{8'h00, 8'h10, 8'h14, 8'h14, 8'h18, 8'h08};
  logic           sp[6] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b1};

  always #10 sys_clk = ~sys_clk;

  scc_sync_ctrl #(.POL_CNT_W(4), .POL_DIV(4'h1), .VSEP_MIN(16'h0008)) dut (
    .sys_clk(sys_clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
    .lineSyncIn(lineSyncIn), .frameSyncIn(frameSyncIn), .clampIn(clampIn),
    .holdoverIn(holdoverIn), .sleep_pin(sleep_pin), .frameSyncPinIn(frameSyncPinIn),
    .frame_sync_out(frame_sync_out), .frameSyncOe(frameSyncOe),
    .regen_line_sync_out(regen_line_sync_out), .addr_lsb_strap(addr_lsb_strap),
    .clampActive(clampActive), .pllHoldover(pllHoldover),
    .extClkSelect(extClkSelect), .sleepActive(sleepActive));

  scc_src_model src (
    .sys_clk(sys_clk), .lineOn(lineOn), .strapLvl(strapLvl), .frameSyncOe(frameSyncOe),
    .frame_sync_out(frame_sync_out), .lineSyncIn(lineSyncIn),
    .frameSyncPinIn(frameSyncPinIn));

  // ------------------------------------------------------------
  // Bus and measurement tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      errorCnt++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wb(input logic we, input logic [6:0] idx, input logic [7:0] wd,
                    output logic [31:0] rd);
    int n;
    n = 0;
    wbReq <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: {idx, 2'b00}, sel: 4'hF,
               dat: {24'h00_0000, wd}};
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbRsp.ack !== 1'b1 && n < 50);
    rd = wbRsp.dat;
    check("ack", wbRsp.ack, 1'b1);
    wbReq <= '0;
    @(posedge sys_clk);
  endtask

  task automatic wr(input logic [6:0] idx, input logic [7:0] wd);
    logic [31:0] rd;
    wb(1'b1, idx, wd, rd);
  endtask

  task automatic rdc(input logic [6:0] idx, input logic [7:0] exp);
    logic [31:0] rd;
    wb(1'b0, idx, 8'h00, rd);
    check("register", rd, {24'h00_0000, exp});
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Cycles from a line pin edge to the output rising, then its high time
  task automatic gap(input logic lvl, input logic sel, output int n, output int w);
    n = 0;
    w = 0;
    while (lineSyncIn !== !lvl) @(posedge sys_clk);
    while (lineSyncIn !== lvl) @(posedge sys_clk);
    while ((sel ? clampActive : regen_line_sync_out) !== 1'b1 && n < 200) begin
      @(posedge sys_clk);
      n++;
    end
    while ((sel ? clampActive : regen_line_sync_out) === 1'b1 && w < 200) begin
      @(posedge sys_clk);
      w++;
    end
  endtask

  task automatic doReset();
    srst <= 1'b1;
    wt(6);
    srst <= 1'b0;
    wt(8);
  endtask

  task automatic reportAndStop();
    $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
    if (errorCnt == 0 && samplesChecked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Tests
  // ------------------------------------------------------------
  initial begin
    doReset();
    check("strap", addr_lsb_strap, 1'b1);
    for (int i = 0; i < 13; i++) begin
      rdc(ri[i], re[i]);
    end
    $display("test reset done");
    wr(7'h03, 8'h04);
    check("extClk", extClkSelect, 1'b1);
    holdoverIn <= 1'b1;
    wt(6);
    check("hold", pllHoldover, 1'b1);
    wr(7'h03, 8'h00);
    wt(2);
    check("extClk", extClkSelect, 1'b0);
    check("hold", pllHoldover, 1'b1);
    holdoverIn <= 1'b0;
    wt(6);
    check("hold", pllHoldover, 1'b0);
    $display("test clock done");
    wr(7'h12, 8'h30);
    lineOn <= 1'b1;
    gap(1'b1, 1'b0, a, d);
    gap(1'b1, 1'b0, a, d);
    check("lineWidth", d, 32);
    wr(7'h12, 8'h20);
    gap(1'b1, 1'b0, b, d);
    gap(1'b1, 1'b0, b, d);
    check("leadEdge", b - a, 8);
    wr(7'h12, 8'h30);
    $display("test line done");
    // Pin held high: internal timing must ignore it
    clampIn <= 1'b1;
    gap(1'b0, 1'b1, a, d);
    gap(1'b0, 1'b1, a, d);
    check("clampDur", d, 16);
    wr(7'h43, 8'h0C);
    gap(1'b0, 1'b1, b, d);
    gap(1'b0, 1'b1, b, d);
    check("clampDelay", b - a, 8);
    wr(7'h1B, 8'hC0);
    wr(7'h18, 8'hD0);
    wt(6);
    check("clampExt", clampActive, 1'b1);
    clampIn <= 1'b0;
    wt(6);
    check("clampExt", clampActive, 1'b0);
    wr(7'h1B, 8'h80);
    wt(6);
    check("clampLow", clampActive, 1'b1);
    wr(7'h18, 8'hC0);
    $display("test clamp done");
    for (int i = 0; i < 6; i++) begin
      wr(7'h1E, sr[i]);
      sleep_pin <= sp[i];
      wt(6);
      check("sleep", sleepActive, sr[i][4] & (sr[i][3] | (sp[i] == sr[i][2])));
    end
    $display("test sleep done");
    wr(7'h14, 8'h30);
    frameSyncIn <= 1'b1;
    wt(6);
    check("frame", frame_sync_out, 1'b1);
    frameSyncIn <= 1'b0;
    wt(6);
    check("frame", frame_sync_out, 1'b0);
    wr(7'h15, 8'h02);
    wr(7'h14, 8'h38);
    frameSyncIn <= 1'b1;
    wt(300);
    check("frameWidth", frame_sync_out, 1'b0);
    frameSyncIn <= 1'b0;
    wr(7'h42, 8'h00);
    wt(6);
    check("framePol", frame_sync_out, 1'b1);
    // Line pin held low and taken as active low: a long composite pulse
    lineOn <= 1'b0;
    wr(7'h14, 8'h30);
    wr(7'h42, 8'h03);
    wt(70);
    wr(7'h12, 8'h20);
    wt(20);
    check("frameSep", frame_sync_out, 1'b1);
    wr(7'h12, 8'h30);
    wt(6);
    check("frameSep", frame_sync_out, 1'b0);
    $display("test frame done");
    lineOn <= 1'b0;
    wt(100);
    wr(7'h41, 8'h00);
    wt(4);
    check("linePol", regen_line_sync_out, 1'b1);
    strapLvl <= 1'b0;
    doReset();
    check("strap", addr_lsb_strap, 1'b0);
    rdc(7'h45, 8'h0F);
    $display("test polarity done");
    reportAndStop();
  end

  initial begin
    wt(20000);
    errorCnt++;
    reportAndStop();
  end
endmodule

bind scc_sync_ctrl scc_sync_ctrl_assertions u_chk (
  .sys_clk(sys_clk), .srst(srst), .wbReq(wbReq), .wbRsp(wbRsp),
  .holdoverIn(holdoverIn), .frameSyncOe(frameSyncOe), .addr_lsb_strap(addr_lsb_strap),
  .regen_line_sync_out(regen_line_sync_out), .pllHoldover(pllHoldover));
